// *** rtl/pxd_core.sv ***
// Execution sequencer for the extended pointer-arithmetic instruction group.
`timescale 1ns/100ps
module pxd_core
  import pxd_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Configuration, level from the fuse logic on this clock
  input wire logic ext_en_i,
  // Fetched instruction
  input wire logic instr_valid_i,
  input wire logic [PXD_INS_W-1:0] instr_i,
  input wire logic [PXD_PC_W-1:0] pc_i,
  // Core registers read by the block
  input wire logic [7:0] working_register_i,
  input wire logic [7:0] program_counter_high_latch_i,
  input wire logic [7:0] program_counter_upper_latch_i,
  input wire logic [PXD_PC_W-1:0] return_stack_top_i,
  input wire logic [7:0] data_rd_i,
  // Data space access
  output logic [PXD_PTR_W-1:0] data_addr_o,
  output logic data_rd_o,
  output logic data_we_o,
  output logic [7:0] data_wr_o,
  // Program flow
  output logic pc_load_o,
  output logic [PXD_PC_W-1:0] pc_o,
  output logic push_o,
  output logic [PXD_PC_W-1:0] push_addr_o,
  output logic pop_o,
  output logic flush_o,
  // Pointer registers
  output logic [PXD_PTR_W-1:0] ptr0_o,
  output logic [PXD_PTR_W-1:0] ptr1_o,
  output logic [PXD_PTR_W-1:0] ptr2_o,
  output logic busy_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    pxd_state_t st;
    logic [2:0][PXD_PTR_W-1:0] ptr;
    logic dst_idx;
    logic busy;
    logic [PXD_PTR_W-1:0] addr;
    logic rd;
    logic we;
    logic [7:0] wdat;
    logic pc_load;
    logic [PXD_PC_W-1:0] pc;
    logic push;
    logic [PXD_PC_W-1:0] push_addr;
    logic pop;
    logic flush;
  } pxd_core_s_t;

  pxd_core_s_t s_q;
  pxd_core_s_t s_d;
  pxd_op_t op;
  logic [1:0] sel;
  logic [PXD_PTR_W-1:0] alu_in;
  logic [PXD_PTR_W-1:0] alu_res;
  logic [PXD_PTR_W-1:0] sp;

  // ****************************************************************
  // Decode and arithmetic
  // ****************************************************************
  pxd_decode u_dec (
    .instr_i(instr_i),
    .ext_en_i(ext_en_i),
    .op_o(op)
  );

  // The return forms always steer the stack pointer, whatever the selector says.
  assign sel = (instr_i[7:6] == PXD_SEL_STACK) ? 2'(PXD_STACK_PTR_IDX) : instr_i[7:6];
  assign alu_in = s_q.ptr[sel];
  assign sp = s_q.ptr[PXD_STACK_PTR_IDX];

  pxd_ptr_alu u_alu (
    .ptr_i(alu_in),
    .lit_i(instr_i[5:0]),
    .sub_i(instr_i[8]),
    .res_o(alu_res)
  );

  // Index an offset off the software stack pointer.
  function automatic logic [PXD_PTR_W-1:0] idx_addr(input logic [PXD_PTR_W-1:0] base,
                                                     input logic [6:0] off);
    idx_addr = base + {{(PXD_PTR_W-7){1'b0}}, off};
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Strobes last one cycle; the pointers, move context, address, write data, pc and push address persist.
  always_comb begin
    s_d = s_q;
    s_d.rd = 1'b0;
    s_d.we = 1'b0;
    s_d.pc_load = 1'b0;
    s_d.push = 1'b0;
    s_d.pop = 1'b0;
    s_d.flush = 1'b0;
    unique case (s_q.st)
      PXD_ST_EXEC: begin
        if (instr_valid_i) begin
          unique case (op)
            PXD_ADD: s_d.ptr[sel] = alu_res;
            PXD_SUB: s_d.ptr[sel] = alu_res;
            PXD_ADD_RET, PXD_SUB_RET: begin
              s_d.ptr[PXD_STACK_PTR_IDX] = alu_res;
              s_d.pc_load = 1'b1;
              s_d.pc = return_stack_top_i;
              s_d.pop = 1'b1;
              s_d.flush = 1'b1;
              s_d.st = PXD_ST_NOP;
            end
            PXD_CALL_VIA_W: begin
              s_d.push = 1'b1;
              s_d.push_addr = pc_i + PXD_PC_STEP;
              s_d.pc_load = 1'b1;
              s_d.pc = {program_counter_upper_latch_i[4:0], program_counter_high_latch_i,
                        working_register_i};
              s_d.flush = 1'b1;
              s_d.st = PXD_ST_NOP;
            end
            PXD_PUSH: begin
              s_d.we = 1'b1;
              s_d.addr = sp;
              s_d.wdat = instr_i[7:0];
              s_d.ptr[PXD_STACK_PTR_IDX] = sp - 12'h001;
            end
            PXD_MOVE: begin
              s_d.rd = 1'b1;
              s_d.addr = idx_addr(sp, instr_i[6:0]);
              s_d.dst_idx = instr_i[7];
              s_d.st = PXD_ST_MOVE2;
            end
            default: ;
          endcase
        end
      end
      PXD_ST_NOP: s_d.st = PXD_ST_EXEC;
      PXD_ST_MOVE2: begin
        if (instr_valid_i) begin
          s_d.we = 1'b1;
          s_d.wdat = data_rd_i;
          s_d.addr = s_q.dst_idx ? idx_addr(sp, instr_i[6:0]) : instr_i[11:0];
          s_d.st = PXD_ST_EXEC;
        end
      end
      default: s_d.st = PXD_ST_EXEC;
    endcase
    // Busy is registered beside the state, so the output needs no decode after the flop.
    s_d.busy = (s_d.st != PXD_ST_EXEC);
    if (!rst_n_i) begin
      s_d = '0;
      s_d.st = PXD_ST_EXEC;
      s_d.ptr = {3{PXD_PTR_RST}};
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign data_addr_o = s_q.addr;
  assign data_rd_o = s_q.rd;
  assign data_we_o = s_q.we;
  assign data_wr_o = s_q.wdat;
  assign pc_load_o = s_q.pc_load;
  assign pc_o = s_q.pc;
  assign push_o = s_q.push;
  assign push_addr_o = s_q.push_addr;
  assign pop_o = s_q.pop;
  assign flush_o = s_q.flush;
  assign ptr0_o = s_q.ptr[0];
  assign ptr1_o = s_q.ptr[1];
  assign ptr2_o = s_q.ptr[2];
  assign busy_o = s_q.busy;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Pointer add and subtract finish in one cycle and touch nothing else.
  chk_add_ptr_val: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == PXD_ST_EXEC && instr_valid_i && op == PXD_ADD && sel == 2'h0)
    |=> ptr0_o == $past(ptr0_o) + {6'h00, $past(instr_i[5:0])})
    else $error("pointer add wrong");
  chk_add_ptr_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == PXD_ST_EXEC && instr_valid_i && op == PXD_ADD && sel == 2'h0)
    |=> $stable(ptr1_o) && $stable(ptr2_o) && !data_we_o && !pc_load_o && !busy_o)
    else $error("pointer add touched other state");
  chk_sub_ptr_val: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == PXD_ST_EXEC && instr_valid_i && op == PXD_SUB && sel == 2'h1)
    |=> ptr1_o == $past(ptr1_o) - {6'h00, $past(instr_i[5:0])})
    else $error("pointer subtract wrong");
  // A step below zero must come back modulo the pointer width, never saturate.
  chk_sub_ptr_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == PXD_ST_EXEC && instr_valid_i && op == PXD_SUB && sel == 2'h2)
    |=> ptr2_o == $past(ptr2_o) - {6'h00, $past(instr_i[5:0])})
    else $error("pointer subtract did not wrap");

  // Return forms steer only the stack pointer, then spend one cycle refilling.
  chk_ret_sp_add: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == PXD_ST_EXEC && instr_valid_i && op == PXD_ADD_RET)
    |=> ptr2_o == $past(ptr2_o) + {6'h00, $past(instr_i[5:0])}
        && $stable(ptr0_o) && $stable(ptr1_o))
    else $error("add and return pointer wrong");
  chk_ret_sp_sub: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == PXD_ST_EXEC && instr_valid_i && op == PXD_SUB_RET)
    |=> ptr2_o == $past(ptr2_o) - {6'h00, $past(instr_i[5:0])}
        && $stable(ptr0_o) && $stable(ptr1_o))
    else $error("subtract and return pointer wrong");
  chk_ret_pc_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == PXD_ST_EXEC && instr_valid_i && (op == PXD_ADD_RET || op == PXD_SUB_RET))
    |=> pc_load_o && pop_o && pc_o == $past(return_stack_top_i))
    else $error("return did not load pc");
  chk_addret_nop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == PXD_ST_EXEC && instr_valid_i && op == PXD_ADD_RET)
    |=> busy_o ##1 (!busy_o && !data_we_o && !pc_load_o && !pop_o))
    else $error("add and return second cycle not a nop");
  chk_ret_nop_cyc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == PXD_ST_EXEC && instr_valid_i && op == PXD_SUB_RET)
    |=> busy_o ##1 (!busy_o && !data_we_o && !pc_load_o))
    else $error("second cycle not a nop");
  // A word presented during the refill cycle belongs to the old flow and is dropped.
  chk_nop_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == PXD_ST_NOP)
    |=> $stable(ptr0_o) && $stable(ptr1_o) && $stable(ptr2_o) && !busy_o && !data_we_o)
    else $error("word taken during refill cycle");

  // Call through the working register pushes, jumps and then refills.
  chk_call_w_push: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == PXD_ST_EXEC && instr_valid_i && op == PXD_CALL_VIA_W)
    |=> push_o && push_addr_o == $past(pc_i) + PXD_PC_STEP
        && pc_o[7:0] == $past(working_register_i))
    else $error("call through W wrong");
  chk_call_w_page: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == PXD_ST_EXEC && instr_valid_i && op == PXD_CALL_VIA_W)
    |=> pc_load_o && pc_o[20:8] == {$past(program_counter_upper_latch_i[4:0]),
        $past(program_counter_high_latch_i)})
    else $error("call through W page wrong");
  chk_call_w_nop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == PXD_ST_EXEC && instr_valid_i && op == PXD_CALL_VIA_W)
    |=> busy_o && flush_o ##1 (!busy_o && !push_o && !pc_load_o))
    else $error("call through W not two cycles");

  // Literal push writes at the old stack pointer in a single cycle.
  chk_push_lit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == PXD_ST_EXEC && instr_valid_i && op == PXD_PUSH)
    |=> data_we_o && data_addr_o == $past(ptr2_o) && ptr2_o == $past(ptr2_o) - 12'h001)
    else $error("push literal wrong");
  chk_push_data: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == PXD_ST_EXEC && instr_valid_i && op == PXD_PUSH)
    |=> data_wr_o == $past(instr_i[7:0]) && !busy_o)
    else $error("push literal data wrong");

  // Moves read the source in the first cycle and write in the second.
  chk_move_src: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == PXD_ST_EXEC && instr_valid_i && op == PXD_MOVE)
    |=> data_rd_o && data_addr_o == $past(ptr2_o) + {5'h00, $past(instr_i[6:0])})
    else $error("move source address wrong");
  chk_move_two_cyc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == PXD_ST_EXEC && instr_valid_i && op == PXD_MOVE)
    |=> busy_o && !data_we_o)
    else $error("move did not wait for its second word");
  chk_move_abs_dst: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == PXD_ST_MOVE2 && instr_valid_i && !s_q.dst_idx)
    |=> data_we_o && data_addr_o == $past(instr_i[11:0]) && data_wr_o == $past(data_rd_i))
    else $error("move to absolute wrong");
  chk_move_idx_dst: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == PXD_ST_MOVE2 && instr_valid_i && s_q.dst_idx)
    |=> data_we_o && data_addr_o == $past(ptr2_o) + {5'h00, $past(instr_i[6:0])})
    else $error("move to indexed wrong");

  // With the extended set off no pointer, write or jump may follow.
  chk_ext_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!ext_en_i && !busy_o)
    |=> !data_we_o && !pc_load_o && $stable(ptr0_o) && $stable(ptr1_o) && $stable(ptr2_o))
    else $error("extended op ran while disabled");

endmodule // pxd_core

// *** rtl/pxd_decode.sv ***
// Opcode classifier for the extended instruction group.
`timescale 1ns/100ps
module pxd_decode
  import pxd_pkg::*;
(
  // Instruction word and enable
  input wire logic [PXD_INS_W-1:0] instr_i,
  input wire logic ext_en_i,
  // Classification
  output pxd_op_t op_o
);

  // Classify the word; everything is ignored while the extended set is off.
  always_comb begin
    op_o = PXD_NONE;
    if (ext_en_i) begin
      if (instr_i[15:8] == PXD_OP_ADD_PTR) begin
        op_o = (instr_i[7:6] == PXD_SEL_STACK) ? PXD_ADD_RET : PXD_ADD;
      end else if (instr_i[15:8] == PXD_OP_SUB_PTR) begin
        op_o = (instr_i[7:6] == PXD_SEL_STACK) ? PXD_SUB_RET : PXD_SUB;
      end else if (instr_i[15:8] == PXD_OP_PUSH_LIT) begin
        op_o = PXD_PUSH;
      end else if (instr_i[15:8] == PXD_OP_MOVE_IDX) begin
        op_o = PXD_MOVE;
      end else if (instr_i == PXD_OP_CALL_W) begin
        op_o = PXD_CALL_VIA_W;
      end
    end
  end

endmodule // pxd_decode

// *** rtl/pxd_pkg.sv ***
// Shared constants and types for the extended pointer-arithmetic instruction decoder.
package pxd_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int PXD_PTR_W = 12;
  localparam int PXD_PC_W = 21;
  localparam int PXD_INS_W = 16;

  // ****************************************************************
  // Opcode fields
  // ****************************************************************
  localparam logic [7:0] PXD_OP_ADD_PTR = 8'he8;
  localparam logic [7:0] PXD_OP_SUB_PTR = 8'he9;
  localparam logic [7:0] PXD_OP_PUSH_LIT = 8'hea;
  localparam logic [7:0] PXD_OP_MOVE_IDX = 8'heb;
  localparam logic [3:0] PXD_OP_SECOND = 4'hf;
  localparam logic [15:0] PXD_OP_CALL_W = 16'h0014;
  localparam logic [1:0] PXD_SEL_STACK = 2'h3;
  localparam int PXD_STACK_PTR_IDX = 2;
  localparam logic [PXD_PC_W-1:0] PXD_PC_STEP = 21'h000002;
  localparam logic [11:0] PXD_PTR_RST = 12'h000;

  // ****************************************************************
  // Decoded operations
  // ****************************************************************
  typedef enum logic [7:0] {
    PXD_NONE = 8'h01,
    PXD_ADD = 8'h02,
    PXD_SUB = 8'h04,
    PXD_ADD_RET = 8'h08,
    PXD_SUB_RET = 8'h10,
    PXD_CALL_VIA_W = 8'h20,
    PXD_PUSH = 8'h40,
    PXD_MOVE = 8'h80
  } pxd_op_t;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [3:0] {
    PXD_ST_EXEC = 4'h1,
    PXD_ST_NOP = 4'h2,
    PXD_ST_MOVE2 = 4'h4,
    PXD_ST_SPARE = 4'h8
  } pxd_state_t;

endpackage

// *** rtl/pxd_ptr_alu.sv ***
// Pointer adder and subtracter for literal offsets.
`timescale 1ns/100ps
module pxd_ptr_alu
  import pxd_pkg::*;
(
  // Operands
  input wire logic [PXD_PTR_W-1:0] ptr_i,
  input wire logic [5:0] lit_i,
  input wire logic sub_i,
  // Result
  output logic [PXD_PTR_W-1:0] res_o
);

  logic [PXD_PTR_W-1:0] lit_ext;

  assign lit_ext = {{(PXD_PTR_W-6){1'b0}}, lit_i};
  assign res_o = sub_i ? ptr_i - lit_ext : ptr_i + lit_ext;

endmodule // pxd_ptr_alu

// *** test/pxd_core_tb.sv ***
// Self-checking bench for the extended pointer-arithmetic sequencer.
`timescale 1ns/100ps
module testbench import pxd_pkg::*;;

  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ext_en_i = 1'b1;
  logic instr_valid_i = 1'b0;
  logic [PXD_INS_W-1:0] instr_i = '0;
  logic [PXD_PC_W-1:0] pc_i = '0;
  logic [PXD_PC_W-1:0] return_stack_top_i = '0;
  logic [7:0] working_register_i = '0;
  logic [7:0] program_counter_high_latch_i = '0;
  logic [7:0] program_counter_upper_latch_i = '0;
  logic [7:0] data_rd_i = '0;
  logic [PXD_PTR_W-1:0] data_addr_o, ptr0_o, ptr1_o, ptr2_o;
  logic data_rd_o, data_we_o, pc_load_o, push_o, pop_o, flush_o, busy_o;
  logic [PXD_PC_W-1:0] pc_o, push_addr_o;
  logic [7:0] data_wr_o;
  int mismatches = 0;
  int checked = 0;
  int p[3] = '{0, 0, 0}; // Reference copy of the three pointers.
  int k, z, d, rd;

  // Free-running 100 MHz clock.
  always #5 clk_i = ~clk_i;

  pxd_core uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ext_en_i(ext_en_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .pc_i(pc_i),
    .working_register_i(working_register_i),
    .program_counter_high_latch_i(program_counter_high_latch_i),
    .program_counter_upper_latch_i(program_counter_upper_latch_i),
    .return_stack_top_i(return_stack_top_i), .data_rd_i(data_rd_i),
    .data_addr_o(data_addr_o), .data_rd_o(data_rd_o), .data_we_o(data_we_o),
    .data_wr_o(data_wr_o), .pc_load_o(pc_load_o), .pc_o(pc_o), .push_o(push_o),
    .push_addr_o(push_addr_o), .pop_o(pop_o), .flush_o(flush_o), .ptr0_o(ptr0_o),
    .ptr1_o(ptr1_o), .ptr2_o(ptr2_o), .busy_o(busy_o));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Four-state compare, so an unknown output never passes.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk_ptrs;
    chk(ptr0_o, p[0]);
    chk(ptr1_o, p[1]);
    chk(ptr2_o, p[2]);
  endtask

  // Valid is left high so back-to-back words never toggle it within one step.
  task automatic issue(input logic [15:0] w);
    instr_i = w;
    instr_valid_i = 1'b1;
    @(negedge clk_i);
  endtask

  // An add to pointer 0 that must be swallowed by the refill cycle.
  task automatic nop_cycle;
    issue({PXD_OP_ADD_PTR, 8'h3f});
    chk_ptrs;
    chk({pc_load_o, push_o, pop_o, busy_o}, 4'h0);
  endtask

  task automatic tally_and_finish;
    if (mismatches == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // A hang is cut short after a fixed budget of cycles.
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    tally_and_finish;
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    void'($urandom(89));
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    // subtract first so the pointer wraps below zero.
    for (int f = 0; f < 3; f++) begin
      for (int s = 1; s >= 0; s--) begin
        k = (f == 0) ? 63 : $urandom_range(63);
        issue({s ? PXD_OP_SUB_PTR : PXD_OP_ADD_PTR, 2'(f), 6'(k)});
        p[f] = (s ? p[f] - k : p[f] + k) & 'hfff;
        chk_ptrs;
      end
    end
    for (int s = 0; s < 2; s++) begin
      k = $urandom_range(63);
      return_stack_top_i = 21'($urandom);
      issue({s ? PXD_OP_SUB_PTR : PXD_OP_ADD_PTR, PXD_SEL_STACK, 6'(k)});
      p[2] = (s ? p[2] - k : p[2] + k) & 'hfff;
      chk_ptrs;
      chk(pc_o, return_stack_top_i);
      chk({pc_load_o, pop_o, flush_o, busy_o}, 4'hf);
      nop_cycle;
    end
    pc_i = 21'($urandom);
    working_register_i = 8'($urandom);
    program_counter_high_latch_i = 8'($urandom);
    program_counter_upper_latch_i = 8'($urandom);
    issue(PXD_OP_CALL_W);
    chk(push_addr_o, 21'(pc_i + PXD_PC_STEP));
    chk(pc_o, {program_counter_upper_latch_i[4:0], program_counter_high_latch_i,
      working_register_i});
    chk({push_o, pc_load_o, busy_o}, 3'h7);
    nop_cycle;
    k = $urandom_range(255);
    issue({PXD_OP_PUSH_LIT, 8'(k)});
    chk({data_we_o, data_addr_o, data_wr_o}, {1'b1, 12'(p[2]), 8'(k)});
    p[2] = (p[2] - 1) & 'hfff;
    chk_ptrs;
    // both two-word moves, back to back.
    for (int s = 0; s < 2; s++) begin
      z = $urandom_range(127);
      d = $urandom_range(s ? 127 : 4095);
      rd = $urandom_range(255);
      issue({PXD_OP_MOVE_IDX, 1'(s), 7'(z)});
      chk({data_rd_o, busy_o, data_addr_o}, {2'b11, 12'(p[2] + z)});
      data_rd_i = 8'(rd);
      issue({PXD_OP_SECOND, s ? {5'($urandom), 7'(d)} : 12'(d)});
      chk({data_we_o, data_addr_o, data_wr_o},
        {1'b1, 12'(s ? p[2] + d : d), 8'(rd)});
    end
    // nothing decodes while the extended set is off.
    ext_en_i = 1'b0;
    issue({PXD_OP_ADD_PTR, 2'h1, 6'h3f});
    chk_ptrs;
    issue(PXD_OP_CALL_W);
    chk({push_o, pc_load_o, busy_o}, 3'h0);
    instr_valid_i = 1'b0;
    @(negedge clk_i);
    tally_and_finish;
  end

endmodule // testbench
